// ---- core/brpl_pkg.sv ----
// shared constants and types for the beacon reply pulse logic
package brpl_pkg;

	// timing clock
	localparam int CLK_MHZ      = 10;

	// pulse pair spacings, leading edge to leading edge
	localparam int SPC_X_US     = 12;
	localparam int SPC_IY_US    = 36;
	localparam int SPC_RY_US    = 30;
	localparam int TOL_NS       = 500;
	localparam int PULSE_NS     = 3500;
	localparam int DEAD_US      = 60;
	localparam int REPLY_US     = 50;
	localparam int SQ_PPS       = 800;
	localparam int ID_PERIOD_S  = 30;
	localparam int ID_WINDOW_MS = 3000;
	localparam int ID_PAIR_US   = 100;

	// derived cycle counts
	localparam int SPC_X_CYC     = SPC_X_US * CLK_MHZ;
	localparam int SPC_IY_CYC    = SPC_IY_US * CLK_MHZ;
	localparam int SPC_RY_CYC    = SPC_RY_US * CLK_MHZ;
	localparam int TOL_CYC       = (TOL_NS * CLK_MHZ) / 1000;
	localparam int PULSE_CYC     = (PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int DEAD_CYC      = DEAD_US * CLK_MHZ;
	localparam int REPLY_CYC     = REPLY_US * CLK_MHZ;
	localparam int SQ_AVG_CYC    = (CLK_MHZ * 1000000) / SQ_PPS;
	localparam int ID_PERIOD_CYC = ID_PERIOD_S * CLK_MHZ * 1000000;
	localparam int ID_WINDOW_CYC = ID_WINDOW_MS * CLK_MHZ * 1000;
	localparam int ID_PAIR_CYC   = ID_PAIR_US * CLK_MHZ;

	// widths and seeds
	localparam int            CNT_W       = 10;
	localparam int            TB_W        = 16;
	localparam int            SQ_SPREAD_W = 12;
	localparam int            FIFO_DEPTH  = 8;
	localparam logic [15:0]   LFSR_SEED   = 16'hace1;

	typedef enum logic [1:0] {
		KIND_NONE,
		KIND_IDENT,
		KIND_REPLY,
		KIND_SQUIT
	} brpl_kind_e;

	typedef struct packed {
		logic       gate;
		brpl_kind_e kind;
	} brpl_tx_s;

	typedef struct packed {
		logic [TB_W-1:0] due;
	} brpl_reply_s;

	// pair spacing for the selected channel mode
	function automatic logic [CNT_W-1:0] pair_spacing(input logic y, input logic is_reply);
		if (!y)
			return CNT_W'(SPC_X_CYC);
		return is_reply ? CNT_W'(SPC_RY_CYC) : CNT_W'(SPC_IY_CYC);
	endfunction

endpackage

// ---- core/brpl_fifo.sv ----
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module brpl_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;

	assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data  = mem[rd_ptr[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule // brpl_fifo

// ---- core/brpl_pulse_logic.sv ----
// pulse pair decoder, reply delay, identity and squitter merge
`timescale 1ns/10ps
// Function
// [RULE1] short mode: all pairs spaced 12 us
// [RULE2] long mode: 36 us received, 30 us sent
// [RULE3] decoder passes only correctly spaced pairs
// [RULE4] priority ident, reply, squitter; never collide
// [RULE5] ident keyed as pair trains every 30 s
// [RULE6] decodes ignored while ident is keyed
// [RULE7] replies outside ident, ahead of squitter
// [RULE8] 60 us dead-time blank after decode
// [RULE9] reply sent 50 us after reception
// [RULE10] random squitter fills to 800 pairs/s
// [RULE11] interrogator sends 12 us, 3.5 us pairs
// [RULE12] replies only for validated interrogations
// [RULE13] interrogator times from its first pulse
// [RULE14] interrogator keeps only its own replies
// [RULE15] interrogator subtracts delay and spacing
// [RULE16] spacing accepted within small tolerance window
module brpl_pulse_logic #(
	parameter int ID_PERIOD = brpl_pkg::ID_PERIOD_CYC,
	parameter int ID_WINDOW = brpl_pkg::ID_WINDOW_CYC,
	parameter int SQ_AVG    = brpl_pkg::SQ_AVG_CYC
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               srst,
	// receiver and mode pins
	input  wire logic               rx_pulse,
	input  wire logic               chan_y,
	// morse key level from the character generator
	input  wire logic               id_key,
	// transmitter gate and status
	output brpl_pkg::brpl_tx_s      tx,
	output logic                    ident_active,
	output logic                    blank_gate
);
	import brpl_pkg::*;

	localparam int ID_W   = $clog2(ID_PERIOD);
	localparam int SQ_MIN = SQ_AVG - (1 << (SQ_SPREAD_W - 1));
	// sized for the largest reload, minimum plus the full random spread
	localparam int SQ_W   = $clog2(SQ_MIN + (1 << SQ_SPREAD_W));

	typedef enum logic [1:0] {ST_IDLE, ST_P1, ST_GAP, ST_P2} brpl_state_e;

	logic              rx_s1, rx_s2, rx_s3;
	logic              y_s1, mode_y;
	logic              rx_edge, listen, in_win, decode;
	logic              armed;
	logic [CNT_W-1:0]  sp_cnt, nom;
	logic [CNT_W-1:0]  dead_cnt;
	logic [TB_W-1:0]   tnow;
	logic [ID_W-1:0]   id_cnt;
	logic [CNT_W-1:0]  id_pace;
	logic [SQ_W-1:0]   sq_cnt;
	logic [15:0]       lfsr;
	brpl_state_e       state;
	logic [CNT_W-1:0]  enc_cnt, enc_spc;
	brpl_reply_s       push_word, head;
	logic              fifo_ready, head_valid, fifo_pop, rep_due;
	logic              start_id, start_rep, start_sq, start_any;
	logic [TB_W-1:0]   late;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; the first stage feeds only the second
	always_ff @(posedge clk) begin
		if (srst) begin
			rx_s1  <= 1'b0;
			rx_s2  <= 1'b0;
			rx_s3  <= 1'b0;
			y_s1   <= 1'b0;
			mode_y <= 1'b0;
		end else begin
			rx_s1  <= rx_pulse;
			rx_s2  <= rx_s1;
			rx_s3  <= rx_s2;
			y_s1   <= chan_y;
			mode_y <= y_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive decoder
	assign rx_edge = rx_s2 && !rx_s3;
	assign nom     = pair_spacing(mode_y, 1'b0);
	// [RULE6] decoder disabled during ident
	assign listen  = !blank_gate && !ident_active;
	// [RULE16] tolerance window on spacing
	assign in_win  = armed && (sp_cnt >= nom - CNT_W'(TOL_CYC)) && (sp_cnt <= nom + CNT_W'(TOL_CYC));
	// [RULE3] only a matching second edge decodes; a full queue also refuses
	assign decode  = listen && rx_edge && in_win && fifo_ready;

	always_ff @(posedge clk) begin
		if (srst) begin
			armed  <= 1'b0;
			sp_cnt <= '0;
		end else if (!listen) begin
			armed  <= 1'b0;
		end else if (rx_edge) begin
			// an unmatched edge may itself be the first of a new pair
			armed  <= !decode;
			sp_cnt <= CNT_W'(1);
		end else if (armed) begin
			if (sp_cnt >= nom + CNT_W'(TOL_CYC))
				armed <= 1'b0;
			else
				sp_cnt <= sp_cnt + 1'b1;
		end
	end

	// [RULE8] dead-time blanking gate
	always_ff @(posedge clk) begin
		if (srst) begin
			dead_cnt   <= '0;
			blank_gate <= 1'b0;
		end else if (decode) begin
			dead_cnt   <= CNT_W'(DEAD_CYC - 1);
			blank_gate <= 1'b1;
		end else begin
			blank_gate <= dead_cnt != '0;
			if (dead_cnt != '0)
				dead_cnt <= dead_cnt - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reply queue; each entry holds the time its reply falls due
	always_ff @(posedge clk) begin
		if (srst)
			tnow <= '0;
		else
			tnow <= tnow + 1'b1;
	end

	// [RULE9] delay counted from the first received pulse
	assign push_word.due = tnow + TB_W'(REPLY_CYC) - TB_W'(nom);

	// [RULE12] only validated decodes enter the queue
	brpl_fifo #(
		.WIDTH ($bits(brpl_reply_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (decode),
		.in_ready  (fifo_ready),
		.in_data   (push_word),
		.out_valid (head_valid),
		.out_ready (fifo_pop),
		.out_data  (head)
	);

	assign late    = tnow - head.due;
	assign rep_due = head_valid && !late[TB_W-1];

	////////////////////////////////////////////////////////////////////////
	// identity window and keying pace
	always_ff @(posedge clk) begin
		if (srst) begin
			id_cnt       <= '0;
			ident_active <= 1'b0;
		end else begin
			id_cnt       <= (id_cnt == ID_W'(ID_PERIOD - 1)) ? '0 : id_cnt + 1'b1;
			// [RULE5] identity cycle repeats every period
			ident_active <= id_cnt < ID_W'(ID_WINDOW);
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			id_pace <= '0;
		else
			id_pace <= (id_pace == '0) ? CNT_W'(ID_PAIR_CYC - 1) : id_pace - 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// squitter timer, restarted by every pair sent
	always_ff @(posedge clk) begin
		if (srst)
			lfsr <= LFSR_SEED;
		else
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
	end

	// [RULE10] random interval averaging the fill rate
	always_ff @(posedge clk) begin
		if (srst)
			sq_cnt <= SQ_W'(SQ_MIN);
		else if (start_any)
			sq_cnt <= SQ_W'(SQ_MIN) + SQ_W'(lfsr[SQ_SPREAD_W-1:0]);
		else if (sq_cnt != '0)
			sq_cnt <= sq_cnt - 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// pair encoder and priority merge
	// [RULE4] fixed priority, one pair at a time
	assign start_id  = (state == ST_IDLE) && ident_active && id_key && (id_pace == '0);
	// [RULE7] replies only outside ident, before squitter
	assign start_rep = (state == ST_IDLE) && !ident_active && rep_due;
	assign start_sq  = (state == ST_IDLE) && !ident_active && !head_valid && (sq_cnt == '0);
	assign start_any = start_id || start_rep || start_sq;
	// stale replies are dropped during ident rather than sent late
	assign fifo_pop  = start_rep || (ident_active && head_valid);

	always_ff @(posedge clk) begin
		if (srst) begin
			state   <= ST_IDLE;
			enc_cnt <= '0;
			enc_spc <= '0;
			tx      <= '{gate: 1'b0, kind: KIND_NONE};
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start_any) begin
						state   <= ST_P1;
						enc_cnt <= CNT_W'(1);
						// [RULE1] [RULE2] reply spacing by mode
						enc_spc <= pair_spacing(mode_y, 1'b1);
						tx.gate <= 1'b1;
						tx.kind <= start_id ? KIND_IDENT : (start_rep ? KIND_REPLY : KIND_SQUIT);
					end
				end
				ST_P1: begin
					enc_cnt <= enc_cnt + 1'b1;
					if (enc_cnt == CNT_W'(PULSE_CYC)) begin
						state   <= ST_GAP;
						tx.gate <= 1'b0;
					end
				end
				ST_GAP: begin
					if (enc_cnt == enc_spc) begin
						state   <= ST_P2;
						enc_cnt <= CNT_W'(1);
						tx.gate <= 1'b1;
					end else begin
						enc_cnt <= enc_cnt + 1'b1;
					end
				end
				ST_P2: begin
					enc_cnt <= enc_cnt + 1'b1;
					if (enc_cnt == CNT_W'(PULSE_CYC)) begin
						state   <= ST_IDLE;
						tx.gate <= 1'b0;
						tx.kind <= KIND_NONE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	localparam int A_REP_MIN = REPLY_CYC - SPC_IY_CYC - 1;
	// queue wait plus a margin for one pair already on air, more than the encoder is ever busy
	localparam int A_REP_MAX = REPLY_CYC + SPC_IY_CYC + 2 * PULSE_CYC;

	logic [CNT_W-1:0] gap_seen;
	logic             gate_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			gap_seen <= '0;
			gate_q   <= 1'b0;
		end else begin
			gate_q   <= tx.gate;
			gap_seen <= (tx.gate && !gate_q) ? CNT_W'(1) : gap_seen + 1'b1;
		end
	end

	property p_spacing_x;
		@(posedge clk) disable iff (srst)
		$rose(tx.gate) && state == ST_P2 && enc_spc == CNT_W'(SPC_X_CYC) |->
			gap_seen == CNT_W'(SPC_X_CYC);
	endproperty
	a_spacing_x: assert property (p_spacing_x) else $error("short mode pair spacing wrong"); // [RULE1]

	property p_spacing_y;
		@(posedge clk) disable iff (srst)
		$rose(tx.gate) && state == ST_P2 && enc_spc == CNT_W'(SPC_RY_CYC) |->
			gap_seen == CNT_W'(SPC_RY_CYC);
	endproperty
	a_spacing_y: assert property (p_spacing_y) else $error("long mode reply spacing wrong"); // [RULE2]

	property p_decode_window;
		@(posedge clk) disable iff (srst)
		decode |-> rx_edge && sp_cnt >= nom - CNT_W'(TOL_CYC) && sp_cnt <= nom + CNT_W'(TOL_CYC);
	endproperty
	a_decode_window: assert property (p_decode_window) else $error("decode outside window"); // [RULE3]

	property p_no_overlap;
		@(posedge clk) disable iff (srst)
		$rose(tx.gate) && state == ST_P1 |-> $past(state) == ST_IDLE && !$past(tx.gate);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("pair started over another"); // [RULE4]

	property p_ident_in_window;
		@(posedge clk) disable iff (srst)
		$rose(tx.gate) && state == ST_P1 && tx.kind == KIND_IDENT |-> $past(ident_active);
	endproperty
	a_ident_in_window: assert property (p_ident_in_window) else $error("ident pair outside window"); // [RULE5]

	property p_no_decode_ident;
		@(posedge clk) disable iff (srst)
		ident_active |-> !decode;
	endproperty
	a_no_decode_ident: assert property (p_no_decode_ident) else $error("decode during ident"); // [RULE6]

	property p_reply_not_ident;
		@(posedge clk) disable iff (srst)
		$rose(tx.gate) && state == ST_P1 && tx.kind != KIND_IDENT |-> !$past(ident_active);
	endproperty
	a_reply_not_ident: assert property (p_reply_not_ident) else $error("pair sent during ident"); // [RULE7]

	property p_dead_time;
		@(posedge clk) disable iff (srst)
		decode |=> blank_gate[*8] ##1 (dead_cnt == CNT_W'(DEAD_CYC - 9));
	endproperty
	a_dead_time: assert property (p_dead_time) else $error("dead-time gate too short"); // [RULE8]

	property p_reply_delay;
		@(posedge clk) disable iff (srst)
		decode && !ident_active |-> ##[A_REP_MIN:A_REP_MAX]
			(($rose(tx.gate) && tx.kind == KIND_REPLY) || ident_active);
	endproperty
	a_reply_delay: assert property (p_reply_delay) else $error("reply not sent after delay"); // [RULE9]

	property p_squit_fill;
		@(posedge clk) disable iff (srst)
		$rose(tx.gate) && state == ST_P1 && tx.kind == KIND_SQUIT |->
			$past(!head_valid && !ident_active && sq_cnt == '0);
	endproperty
	a_squit_fill: assert property (p_squit_fill) else $error("squitter sent with work pending"); // [RULE10]

	property p_reply_validated;
		@(posedge clk) disable iff (srst)
		$rose(tx.gate) && state == ST_P1 && tx.kind == KIND_REPLY |-> $past(fifo_pop && head_valid);
	endproperty
	a_reply_validated: assert property (p_reply_validated) else $error("reply without decode"); // [RULE12]

endmodule // brpl_pulse_logic

// ---- tb/brpl_interrogator.sv ----
// airborne interrogator model: sends pulse pairs and times the replies
`timescale 1ns/10ps
module brpl_interrogator (
	// timing clock
	input  wire logic               clk,
	// rf link, detected pulse levels
	output logic                    rx_pulse,
	input  wire brpl_pkg::brpl_tx_s tx
);
	import brpl_pkg::*;
	int   cyc     = 0;
	int   t_start = 0;
	int   t_first = 0;
	int   transit = -1;
	logic armed   = 1'b0;
	logic gate_d  = 1'b0;
	logic second  = 1'b0;

	initial rx_pulse = 1'b0;

	////////////////////////////////////////////////////////////////
	// fixed width pairs
	task automatic send_pair(input int spacing);
		@(negedge clk);
		// timer starts on own first pulse
		if (!armed)
			t_start = cyc;
		armed = 1'b1;
		for (int i = 0; i < spacing + PULSE_CYC; i++) begin
			rx_pulse = (i < PULSE_CYC) || (i >= spacing);
			@(negedge clk);
		end
		rx_pulse = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc <= cyc + 1;
		gate_d <= tx.gate;
		if (armed && cyc - t_start > 2 * REPLY_CYC) begin
			armed <= 1'b0;
			second <= 1'b0;
		end
		if (armed && tx.gate && !gate_d && tx.kind == KIND_REPLY) begin
			second <= !second;
			if (!second)
				t_first <= cyc;
			else begin
				transit <= cyc - t_start - (cyc - t_first) - REPLY_CYC;
				armed <= 1'b0;
			end
		end
	end
endmodule // brpl_interrogator

// ---- tb/tb.sv ----
// self-checking bench for the beacon reply pulse logic
`timescale 1ns/10ps
module tb;
	import brpl_pkg::*;
	// short ident timing keeps the run near 40k cycles
	localparam int ID_PER = 40000;
	localparam int ID_WIN = 3000;
	localparam int SQ_AV  = 3000;

	logic     clk;
	logic     srst;
	logic     rx_pulse;
	logic     chan_y;
	logic     id_key;
	brpl_tx_s tx;
	logic     ident_active;
	logic     blank_gate;
	int       cyc = 0;
	int       mismatches = 0;
	int       compares = 0;
	int       n_kind[4] = '{default: 0};
	int       id_rise = 0;
	int       id_fall = 0;
	int       bl_rise = 0;
	int       bl_fall = 0;
	logic [1:0] kind_d;
	logic     id_d;
	logic     bl_d;

	brpl_pulse_logic #(.ID_PERIOD(ID_PER), .ID_WINDOW(ID_WIN), .SQ_AVG(SQ_AV)) dut (
		.clk(clk), .srst(srst), .rx_pulse(rx_pulse), .chan_y(chan_y), .id_key(id_key),
		.tx(tx), .ident_active(ident_active), .blank_gate(blank_gate)
	);
	brpl_interrogator intr (.clk(clk), .rx_pulse(rx_pulse), .tx(tx));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#(60000 * 100);
		mismatches++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc <= cyc + 1;
		kind_d <= tx.kind;
		id_d <= ident_active;
		bl_d <= blank_gate;
		if (ident_active && !id_d)
			id_rise <= cyc;
		if (!ident_active && id_d)
			id_fall <= cyc;
		if (blank_gate && !bl_d)
			bl_rise <= cyc;
		if (!blank_gate && bl_d)
			bl_fall <= cyc;
		if (kind_d == KIND_NONE && tx.kind != KIND_NONE)
			n_kind[tx.kind] <= n_kind[tx.kind] + 1;
		if (kind_d != KIND_NONE && tx.kind != KIND_NONE && tx.kind != kind_d)
			check(32'(tx.kind), 32'(kind_d));
		if (ident_active === 1'b1 && tx.kind == KIND_REPLY)
			check(32'(tx.kind), 32'(KIND_NONE));
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wait_kind(input logic [1:0] k);
		int n;
		n = 0;
		while (tx.kind !== k && n < 8000) begin
			@(negedge clk);
			n++;
		end
		check(32'(n < 8000), 32'h1);
	endtask

	task automatic get_pair(output logic [1:0] k, output int w, output int sp);
		int n;
		n = 0;
		while (tx.gate !== 1'b1 && n < 6000) begin
			@(negedge clk);
			n++;
		end
		check(32'(n < 6000), 32'h1);
		k = tx.kind;
		w = 0;
		while (tx.gate === 1'b1 && w < 100) begin
			@(negedge clk);
			w++;
		end
		sp = w;
		while (tx.gate !== 1'b1 && sp < 1000) begin
			@(negedge clk);
			sp++;
		end
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_ident;
		logic [1:0] k;
		int w;
		int sp;
		check(32'(ident_active), 32'h1);
		intr.send_pair(SPC_X_CYC);
		get_pair(k, w, sp);
		check(32'(k), 32'(KIND_IDENT));
		check(32'(sp), 32'(SPC_X_CYC));
		while (ident_active === 1'b1 && cyc < ID_WIN + 100)
			@(negedge clk);
		wait_cyc(700);
		check(32'(id_fall - id_rise), 32'(ID_WIN));
		check(32'(n_kind[KIND_REPLY]), 32'h0);
	endtask

	// start just after a squitter pair so the reply timing is undisturbed
	task automatic t_reply(input logic y, input int sp_in, input int sp_out, input logic dbl);
		logic [1:0] k;
		int w;
		int sp;
		int n0;
		chan_y = y;
		wait_kind(KIND_SQUIT);
		wait_kind(KIND_NONE);
		n0 = n_kind[KIND_REPLY];
		intr.send_pair(sp_in);
		if (dbl)
			intr.send_pair(sp_in);
		get_pair(k, w, sp);
		check(32'(k), 32'(KIND_REPLY));
		check(32'(w), 32'(PULSE_CYC));
		check(32'(sp), 32'(sp_out));
		wait_cyc(700);
		check(32'(intr.transit >= 0 && intr.transit <= 8), 32'h1);
		check(32'(bl_fall - bl_rise), 32'(DEAD_CYC));
		check(32'(n_kind[KIND_REPLY] - n0), 32'h1);
	endtask

	task automatic t_reject;
		int         sps[4] = '{128, 124, 120, 354};
		logic [3:0] ys = 4'hc;
		logic [3:0] ex = 4'h2;
		int         n0;
		for (int i = 0; i < 4; i++) begin
			chan_y = ys[i];
			wait_cyc(10);
			n0 = n_kind[KIND_REPLY];
			intr.send_pair(sps[i]);
			wait_cyc(800);
			check(32'(n_kind[KIND_REPLY] - n0), 32'(ex[i]));
		end
	endtask

	task automatic t_squit;
		int n0;
		n0 = n_kind[KIND_SQUIT];
		wait_cyc(15000);
		check(32'((n_kind[KIND_SQUIT] - n0) inside {[3:7]}), 32'h1);
	endtask

	task automatic t_period;
		int first;
		int n0;
		first = id_rise;
		while (id_rise == first && cyc < ID_PER + 200)
			@(negedge clk);
		n0 = n_kind[KIND_IDENT];
		check(32'(id_rise - first), 32'(ID_PER));
		wait_cyc(1200);
		check(32'(n_kind[KIND_IDENT] > n0), 32'h1);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		srst = 1'b1;
		chan_y = 1'b0;
		id_key = 1'b0;
		repeat (5) @(negedge clk);
		srst = 1'b0;
		id_key = 1'b1;
		wait_cyc(2);
		t_ident();
		t_reply(1'b0, SPC_X_CYC, SPC_X_CYC, 1'b1);
		t_reply(1'b1, SPC_IY_CYC, SPC_RY_CYC, 1'b0);
		t_reject();
		t_squit();
		t_period();
		stop_test();
	end
endmodule // tb
